// >>> cei_pkg.sv
// Purpose: shared constants and types for the codec enable and input select registers
// Assumes: 16-bit registers addressed by an 8-bit register index
// Notes: offsets are register indices on the control interface
package cei_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] power_control_one_off     = 8'h08;
	localparam logic [7:0] power_control_two_off     = 8'h09;
	localparam logic [7:0] power_control_four_off    = 8'h0b;
	localparam logic [7:0] power_control_five_off    = 8'h0c;
	localparam logic [7:0] input_pin_select_off      = 8'h48;
	localparam logic [7:0] left_input_gain_ctrl_off  = 8'h50;
	localparam logic [7:0] right_input_gain_ctrl_off = 8'h51;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int master_subsystem_enable_bit  = 12;
	localparam int core_clock_enable_bit        = 14;
	localparam int analog_bias_enable_bit       = 5;
	localparam int right_preamp_enable_bit      = 9;
	localparam int left_preamp_enable_bit       = 8;
	localparam int gain_preamp_enable_bit       = 15;
	localparam int left_pos_pin_connect_bit     = 0;
	localparam int left_neg_pin_connect_bit     = 1;
	localparam int left_second_pin_connect_bit  = 2;
	localparam int right_pos_pin_connect_bit    = 8;
	localparam int right_neg_pin_connect_bit    = 9;
	localparam int right_second_pin_connect_bit = 10;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic reset_master   = 1'h0;
	localparam logic reset_clock    = 1'h0;
	localparam logic reset_bias     = 1'h0;
	localparam logic reset_preamp   = 1'h0;
	localparam logic reset_pos_pin  = 1'h1;
	localparam logic reset_neg_pin  = 1'h1;
	localparam logic reset_sec_pin  = 1'h0;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic pos;
		logic neg;
		logic second;
	} cei_pins_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} cei_req_t;

endpackage

// >>> cei_pin_sel.sv
// Purpose: one channel's input pin connection selects
// Assumes: clr is synchronous, driven while the codec is held in reset
// Notes: defaults leave the differential pair connected
`timescale 1ns/1ps
module cei_pin_sel (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// control
	input  wire logic              clr,
	input  wire logic              we,
	input  wire cei_pkg::cei_pins_t wval,
	// state
	output cei_pkg::cei_pins_t     pins
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	localparam cei_pkg::cei_pins_t pins_rst = '{
		pos:    cei_pkg::reset_pos_pin,
		neg:    cei_pkg::reset_neg_pin,
		second: cei_pkg::reset_sec_pin
	};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			pins <= pins_rst;
		else if (clr)
			pins <= pins_rst;
		else if (we)
			pins <= wval;
	end

endmodule

// >>> cei_preamp_en.sv
// Purpose: single storage bit for one input preamp enable
// Assumes: two aliased write strobes never carry different data in one cycle
// Notes: either alias location writes the same bit
`timescale 1ns/1ps
module cei_preamp_en (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// control
	input  wire logic clr,
	input  wire logic we_a,
	input  wire logic wd_a,
	input  wire logic we_b,
	input  wire logic wd_b,
	// state
	output logic      en
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	// one flop, so the two aliases can never disagree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			en <= cei_pkg::reset_preamp;
		else if (clr)
			en <= cei_pkg::reset_preamp;
		else if (we_a)
			en <= wd_a;
		else if (we_b)
			en <= wd_b;
	end

endmodule

// >>> cei_regs.sv
// Purpose: codec master enable, clock and bias enables, preamp enables, input pin selects
// Assumes: one register access per cycle on the control port; read data is registered
// Notes: unmapped reads return zero, unmapped writes are ignored
// Functional notes
// RULE1: master enable clear holds every codec register in reset
// RULE2: software sets master, clock and bias enables before using the codec
// RULE3: bias enable is bit 5 of power control one, reset 0
// RULE4: each sub-function stays off until its own enable bit is set
// RULE5: software follows the pop-safe power-up order with its waits
// RULE6: software follows the pop-safe power-down order with its waits
// RULE7: power control two bits 9 and 8 enable right and left preamps
// RULE8: each preamp enable also appears at bit 15 of its gain register
// RULE9: left pin selects at bits 0..2, defaults 1, 1, 0
// RULE10: right pin selects at bits 8..10, defaults 1, 1, 0
// RULE11: clearing master enable returns codec fields to defaults, master keeps value
`timescale 1ns/1ps
module cei_regs (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// control interface
	input  wire cei_pkg::cei_req_t req,
	output logic [15:0]            rdata,
	output logic                   rvalid,
	// codec controls
	output logic                   master_subsystem_enable,
	output logic                   core_clock_enable,
	output logic                   analog_bias_enable,
	output logic                   left_preamp_enable,
	output logic                   right_preamp_enable,
	output cei_pkg::cei_pins_t     left_pins,
	output cei_pkg::cei_pins_t     right_pins
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	wire logic sel_one   = hit(req.addr, cei_pkg::power_control_one_off);
	wire logic sel_two   = hit(req.addr, cei_pkg::power_control_two_off);
	wire logic sel_four  = hit(req.addr, cei_pkg::power_control_four_off);
	wire logic sel_five  = hit(req.addr, cei_pkg::power_control_five_off);
	wire logic sel_pins  = hit(req.addr, cei_pkg::input_pin_select_off);
	wire logic sel_lgain = hit(req.addr, cei_pkg::left_input_gain_ctrl_off);
	wire logic sel_rgain = hit(req.addr, cei_pkg::right_input_gain_ctrl_off);

	// codec reset while master is clear; the master bit itself is outside it
	// a clearing write resets at the same edge, so no cycle shows a stale field
	wire logic master_wr_clear = req.wr && sel_five
		&& !req.wdata[cei_pkg::master_subsystem_enable_bit];
	wire logic codec_clr = !master_subsystem_enable || master_wr_clear; // RULE1 RULE4 RULE11

	// ------------------------------------------------------------
	// master enable (not codec domain)
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			master_subsystem_enable <= cei_pkg::reset_master;
		else if (req.wr && sel_five)
			master_subsystem_enable <= req.wdata[cei_pkg::master_subsystem_enable_bit];
	end

	// ------------------------------------------------------------
	// clock and bias enables
	// ------------------------------------------------------------
	// writes while held in reset are dropped, as the register is in reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			core_clock_enable  <= cei_pkg::reset_clock;
			analog_bias_enable <= cei_pkg::reset_bias;
		end else if (codec_clr) begin // RULE1
			core_clock_enable  <= cei_pkg::reset_clock;
			analog_bias_enable <= cei_pkg::reset_bias;
		end else begin
			if (req.wr && sel_four)
				core_clock_enable <= req.wdata[cei_pkg::core_clock_enable_bit];
			if (req.wr && sel_one)
				analog_bias_enable <= req.wdata[cei_pkg::analog_bias_enable_bit]; // RULE3
		end
	end

	// ------------------------------------------------------------
	// preamp enables, aliased
	// ------------------------------------------------------------
	cei_preamp_en u_left_en (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (codec_clr),
		.we_a  (req.wr && sel_two),
		.wd_a  (req.wdata[cei_pkg::left_preamp_enable_bit]), // RULE7
		.we_b  (req.wr && sel_lgain),
		.wd_b  (req.wdata[cei_pkg::gain_preamp_enable_bit]), // RULE8
		.en    (left_preamp_enable)
	);

	cei_preamp_en u_right_en (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (codec_clr),
		.we_a  (req.wr && sel_two),
		.wd_a  (req.wdata[cei_pkg::right_preamp_enable_bit]), // RULE7
		.we_b  (req.wr && sel_rgain),
		.wd_b  (req.wdata[cei_pkg::gain_preamp_enable_bit]), // RULE8
		.en    (right_preamp_enable)
	);

	// ------------------------------------------------------------
	// input pin selects
	// ------------------------------------------------------------
	wire cei_pkg::cei_pins_t left_w = '{
		pos:    req.wdata[cei_pkg::left_pos_pin_connect_bit],
		neg:    req.wdata[cei_pkg::left_neg_pin_connect_bit],
		second: req.wdata[cei_pkg::left_second_pin_connect_bit]
	}; // RULE9
	wire cei_pkg::cei_pins_t right_w = '{
		pos:    req.wdata[cei_pkg::right_pos_pin_connect_bit],
		neg:    req.wdata[cei_pkg::right_neg_pin_connect_bit],
		second: req.wdata[cei_pkg::right_second_pin_connect_bit]
	}; // RULE10

	cei_pin_sel u_left_pins (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (codec_clr),
		.we    (req.wr && sel_pins),
		.wval  (left_w),
		.pins  (left_pins)
	);

	cei_pin_sel u_right_pins (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (codec_clr),
		.we    (req.wr && sel_pins),
		.wval  (right_w),
		.pins  (right_pins)
	);

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	logic [15:0] next_rdata;

	always_comb begin
		next_rdata = 16'h0000;
		if (sel_one)
			next_rdata[cei_pkg::analog_bias_enable_bit] = analog_bias_enable;
		if (sel_two) begin
			next_rdata[cei_pkg::left_preamp_enable_bit]  = left_preamp_enable;
			next_rdata[cei_pkg::right_preamp_enable_bit] = right_preamp_enable;
		end
		if (sel_four)
			next_rdata[cei_pkg::core_clock_enable_bit] = core_clock_enable;
		if (sel_five)
			next_rdata[cei_pkg::master_subsystem_enable_bit] = master_subsystem_enable;
		if (sel_pins) begin
			next_rdata[cei_pkg::left_pos_pin_connect_bit]     = left_pins.pos;
			next_rdata[cei_pkg::left_neg_pin_connect_bit]     = left_pins.neg;
			next_rdata[cei_pkg::left_second_pin_connect_bit]  = left_pins.second;
			next_rdata[cei_pkg::right_pos_pin_connect_bit]    = right_pins.pos;
			next_rdata[cei_pkg::right_neg_pin_connect_bit]    = right_pins.neg;
			next_rdata[cei_pkg::right_second_pin_connect_bit] = right_pins.second;
		end
		if (sel_lgain)
			next_rdata[cei_pkg::gain_preamp_enable_bit] = left_preamp_enable; // RULE8
		if (sel_rgain)
			next_rdata[cei_pkg::gain_preamp_enable_bit] = right_preamp_enable; // RULE8
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata  <= 16'h0000;
			rvalid <= 1'h0;
		end else begin
			rdata  <= req.rd ? next_rdata : 16'h0000;
			rvalid <= req.rd;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence master_cleared_s;
		!master_subsystem_enable;
	endsequence

	codec_held_reset_a: assert property ( // RULE1
		master_cleared_s |=> (!core_clock_enable && !analog_bias_enable
			&& !left_preamp_enable && !right_preamp_enable))
		else $error("codec field set while master clear");

	pins_default_a: assert property ( // RULE11
		master_cleared_s |=> (left_pins == 3'b110 && right_pins == 3'b110))
		else $error("pin select not at default while master clear");

	bias_write_a: assert property ( // RULE3
		(req.wr && sel_one && master_subsystem_enable)
		|=> analog_bias_enable == $past(req.wdata[5]))
		else $error("bias enable did not follow write");

	left_alias_a: assert property ( // RULE8
		(req.wr && sel_lgain && !sel_two && master_subsystem_enable)
		|=> left_preamp_enable == $past(req.wdata[15]))
		else $error("left gain alias write lost");

	right_alias_a: assert property ( // RULE8
		(req.rd && sel_rgain) |=> rdata[15] == $past(right_preamp_enable) && rvalid)
		else $error("right gain alias read wrong");

	preamp_write_a: assert property ( // RULE7
		(req.wr && sel_two && master_subsystem_enable)
		|=> left_preamp_enable == $past(req.wdata[8])
			&& right_preamp_enable == $past(req.wdata[9]))
		else $error("preamp enables did not follow write");

	left_pins_a: assert property ( // RULE9
		(req.wr && sel_pins && master_subsystem_enable)
		|=> {left_pins.pos, left_pins.neg, left_pins.second}
			== {$past(req.wdata[0]), $past(req.wdata[1]), $past(req.wdata[2])})
		else $error("left pin selects did not follow write");

	right_pins_a: assert property ( // RULE10
		(req.wr && sel_pins && master_subsystem_enable)
		|=> {right_pins.pos, right_pins.neg, right_pins.second}
			== {$past(req.wdata[8]), $past(req.wdata[9]), $past(req.wdata[10])})
		else $error("right pin selects did not follow write");

	master_keeps_a: assert property ( // RULE11
		!(req.wr && sel_five) |=> $stable(master_subsystem_enable))
		else $error("master enable changed without write");

	// ------------------------------------------------------------
	// further checks
	// ------------------------------------------------------------
	sequence master_clear_write_s;
		req.wr && sel_five && !req.wdata[cei_pkg::master_subsystem_enable_bit];
	endsequence

	sequence master_set_write_s;
		req.wr && sel_five && req.wdata[cei_pkg::master_subsystem_enable_bit];
	endsequence

	sequence pins_untouched_s;
		master_subsystem_enable && !(req.wr && (sel_pins || sel_five));
	endsequence

	sequence pin_read_s;
		req.rd && sel_pins;
	endsequence

	codec_no_lag_a: assert property ( // RULE1
		master_cleared_s |-> (!core_clock_enable && !analog_bias_enable
			&& !left_preamp_enable && !right_preamp_enable))
		else $error("codec field set in a master clear cycle");

	pins_no_lag_a: assert property ( // RULE11
		master_cleared_s |-> (left_pins == 3'b110 && right_pins == 3'b110))
		else $error("pin select off default in a master clear cycle");

	clear_write_a: assert property ( // RULE11
		master_clear_write_s |=> (!master_subsystem_enable && !left_preamp_enable
			&& !right_preamp_enable && !core_clock_enable && !analog_bias_enable))
		else $error("master clear write left a codec field set");

	set_write_a: assert property ( // RULE11
		master_set_write_s |=> master_subsystem_enable)
		else $error("master set write lost");

	clock_write_a: assert property ( // RULE1
		(req.wr && sel_four && master_subsystem_enable)
		|=> core_clock_enable == $past(req.wdata[cei_pkg::core_clock_enable_bit]))
		else $error("clock enable did not follow write");

	left_rise_a: assert property ( // RULE4
		$rose(left_preamp_enable) |-> $past(req.wr && (sel_two || sel_lgain)))
		else $error("left preamp enabled without a write");

	right_rise_a: assert property ( // RULE4
		$rose(right_preamp_enable) |-> $past(req.wr && (sel_two || sel_rgain)))
		else $error("right preamp enabled without a write");

	bias_rise_a: assert property ( // RULE4
		$rose(analog_bias_enable) |-> $past(req.wr && sel_one))
		else $error("bias enabled without a write");

	right_alias_write_a: assert property ( // RULE8
		(req.wr && sel_rgain && master_subsystem_enable)
		|=> right_preamp_enable == $past(req.wdata[cei_pkg::gain_preamp_enable_bit]))
		else $error("right gain alias write lost");

	left_alias_read_a: assert property ( // RULE8
		(req.rd && sel_lgain) |=> rvalid && rdata[15] == $past(left_preamp_enable))
		else $error("left gain alias read wrong");

	pins_hold_a: assert property ( // RULE9 RULE10
		pins_untouched_s |=> $stable(left_pins) && $stable(right_pins))
		else $error("pin selects changed without a write");

	bias_read_a: assert property ( // RULE3
		(req.rd && sel_one)
		|=> rvalid && rdata[cei_pkg::analog_bias_enable_bit] == $past(analog_bias_enable))
		else $error("bias enable read wrong");

	left_pins_read_a: assert property ( // RULE9
		pin_read_s
		|=> rdata[2:0] == $past({left_pins.second, left_pins.neg, left_pins.pos}))
		else $error("left pin selects read wrong");

	right_pins_read_a: assert property ( // RULE10
		pin_read_s
		|=> rdata[10:8] == $past({right_pins.second, right_pins.neg, right_pins.pos}))
		else $error("right pin selects read wrong");

endmodule

// >>> tb_cei_regs.sv
// Purpose: self-checking bench for the codec enable and input select registers
// Assumes: inputs change on the falling edge, one idle cycle between accesses
// Notes: rows cover write and read back; refusal cases come before them, alias, master clear and reset cases follow
`timescale 1ns/1ps
module tb_cei_regs;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic               clk;
	logic               rst_b;
	cei_pkg::cei_req_t  req;
	logic [15:0]        rdata;
	logic               rvalid;
	logic               m_en;
	logic               c_en;
	logic               b_en;
	logic               l_en;
	logic               r_en;
	cei_pkg::cei_pins_t lp;
	cei_pkg::cei_pins_t rp;
	wire logic [15:0]   outs = {5'h00, m_en, c_en, b_en, l_en, r_en, lp, rp};
	int                 mismatches;
	int                 check_count;

	// ------------------------------------------------------------
	// rows: address, write data, read back, outputs after write
	// ------------------------------------------------------------
	logic [7:0]  row_addr [11] = '{8'h0b, 8'h08, 8'h09, 8'h48, 8'h50, 8'h51,
		8'h48, 8'h0b, 8'h0c, 8'h30, 8'h08};
	logic [15:0] row_data [11] = '{16'h4000, 16'h0020, 16'h0300, 16'h0404, 16'h0000,
		16'hffff, 16'hffff, 16'h0000, 16'hffff, 16'hffff, 16'hffdf};
	logic [15:0] row_read [11] = '{16'h4000, 16'h0020, 16'h0300, 16'h0404, 16'h0000,
		16'h8000, 16'h0707, 16'h0000, 16'h1000, 16'h0000, 16'h0000};
	logic [15:0] row_outs [11] = '{16'h0636, 16'h0736, 16'h07f6, 16'h07c9, 16'h0749,
		16'h0749, 16'h077f, 16'h057f, 16'h057f, 16'h057f, 16'h047f};

	// ------------------------------------------------------------
	// design
	// ------------------------------------------------------------
	cei_regs uut (
		.clk                     (clk),
		.rst_b                   (rst_b),
		.req                     (req),
		.rdata                   (rdata),
		.rvalid                  (rvalid),
		.master_subsystem_enable (m_en),
		.core_clock_enable       (c_en),
		.analog_bias_enable      (b_en),
		.left_preamp_enable      (l_en),
		.right_preamp_enable     (r_en),
		.left_pins               (lp),
		.right_pins              (rp)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// request held for one whole cycle, released a cycle later
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
	endtask

	// rvalid and rdata stand one cycle only, so sampled at the release
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge clk);
		req = '0;
		chk({15'h0000, rvalid}, 16'h0001);
		chk(rdata, e);
	endtask

	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// watchdog: a run still going at 20000 ns counts as a failure and is ended
	initial begin
		#20000;
		mismatches++;
		complete_run();
	end

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		req = '0;
		rst_b = 1'b0;
		mismatches = 0;
		check_count = 0;
		repeat (3) @(negedge clk);
		chk(outs, 16'h0036);
		rst_b = 1'b1;
		@(negedge clk);
		chk(outs, 16'h0036);
		rd_chk(cei_pkg::power_control_five_off, 16'h0000);
		rd_chk(cei_pkg::input_pin_select_off, 16'h0303);
		// codec writes dropped while master is clear
		reg_wr(cei_pkg::power_control_two_off, 16'h0300);
		reg_wr(cei_pkg::input_pin_select_off, 16'h0404);
		chk(outs, 16'h0036);
		rd_chk(cei_pkg::left_input_gain_ctrl_off, 16'h0000);
		reg_wr(cei_pkg::power_control_five_off, 16'h1000);
		chk(outs, 16'h0436);
		for (int i = 0; i < 11; i++) begin
			reg_wr(row_addr[i], row_data[i]);
			chk(outs, row_outs[i]);
			rd_chk(row_addr[i], row_read[i]);
		end
		// one storage bit seen through both locations
		rd_chk(cei_pkg::power_control_two_off, 16'h0200);
		reg_wr(cei_pkg::power_control_two_off, 16'h0100);
		rd_chk(cei_pkg::left_input_gain_ctrl_off, 16'h8000);
		rd_chk(cei_pkg::right_input_gain_ctrl_off, 16'h0000);
		// master clear returns codec fields to defaults
		reg_wr(cei_pkg::power_control_five_off, 16'h0000);
		chk(outs, 16'h0036);
		rd_chk(cei_pkg::input_pin_select_off, 16'h0303);
		rd_chk(cei_pkg::power_control_two_off, 16'h0000);
		// reset in mid-run acts without a clock edge
		reg_wr(cei_pkg::power_control_five_off, 16'h1000);
		reg_wr(cei_pkg::power_control_two_off, 16'h0300);
		chk(outs, 16'h04f6);
		@(negedge clk);
		rst_b = 1'b0;
		#1;
		chk(outs, 16'h0036);
		@(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk(outs, 16'h0036);
		rd_chk(cei_pkg::power_control_two_off, 16'h0000);
		complete_run();
	end

endmodule
